//--- logic/hif_irq_hub.sv
// Implementation choice: strobed register access.
module hif_irq_hub
  import hif_pkg::*;
(
  input  wire logic              core_clk_i,     // 40 MHz clock
  input  wire logic              rstn_i,         // async reset, low
  input  wire logic              ce_i,           // freezes state when low
  input  wire logic [7:0]        addr_i,         // register address
  input  wire logic [7:0]        wdata_i,        // write data
  input  wire logic              wr_i,           // write strobe
  input  wire logic              rd_i,           // read strobe
  output logic      [7:0]        rdata_o,        // read data, next cycle
  input  wire hif_fwd_t          fwd0_i,         // output port 0 engine
  input  wire hif_fwd_t          fwd1_i,         // output port 1 engine
  input  wire logic [NUM_TX-1:0] tx_event_i,     // transmitter events
  input  wire logic [NUM_TX-1:0] tx_sts_read_i,  // transmitter status read
  input  wire hif_rx_t           rx_i,           // receiver events and reads
  input  wire logic              rx_pin_evt_i,   // async rx port 0 event pin
  output logic                   irq_o,          // host interrupt line
  output logic                   evt_irq_o       // local event interrupt
);
  logic [7:0]         irq_ctl;
  logic [NUM_TX-1:0]  tx_pend;
  logic [NUM_RX-1:0]  rx_pend;
  logic [NUM_RX-1:0]  rd_a_seen;
  logic [NUM_RX-1:0]  rd_b_seen;
  logic [NUM_RX-1:0]  rd_s_seen;
  logic [NUM_EVT-1:0] evt_sts;
  logic [NUM_EVT-1:0] evt_en;
  logic               global_pend_q;
  logic               irq_q;
  logic               pin_sync;
  logic               ok0, ok1, lost0, lost1, lev0, lev1;

  // address decode
  wire rd_fwd  = rd_i && addr_i == ADDR_FORWARD_SYNC_STATUS;
  wire rd_ctl  = rd_i && addr_i == ADDR_IRQ_CTL;
  wire rd_ists = rd_i && addr_i == ADDR_IRQ_STS;
  wire wr_ctl  = wr_i && addr_i == ADDR_IRQ_CTL;
  wire wr_eclr = wr_i && addr_i == ADDR_EVT_CLR;
  wire wr_een  = wr_i && addr_i == ADDR_EVT_EN;

  // register reads clear only when clock enabled
  wire fwd_clr = rd_fwd & ce_i; // [RULE2]

  hif_fwd_port u_port0 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .fwd_i      (fwd0_i),
    .clr_i      (fwd_clr),
    .sync_ok_o  (ok0),
    .lost_o     (lost0),
    .lost_evt_o (lev0)
  );

  hif_fwd_port u_port1 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .fwd_i      (fwd1_i),
    .clr_i      (fwd_clr),
    .sync_ok_o  (ok1),
    .lost_o     (lost1),
    .lost_evt_o (lev1)
  );

  hif_sync3 u_pin_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .async_i    (rx_pin_evt_i),
    .sync_o     (pin_sync)
  );

  logic pin_sync_d;
  wire  pin_rise = pin_sync & ~pin_sync_d;

  // status words
  wire [7:0] fwd_word = {4'h0, lost1, lost0, ok1, ok0};
  wire [NUM_TX-1:0] tx_en = irq_ctl[TX_LSB +: NUM_TX]; // [RULE6]
  wire [NUM_RX-1:0] rx_en = irq_ctl[RX_LSB +: NUM_RX]; // [RULE6]
  wire global_pend = |(tx_pend & tx_en) | |(rx_pend & rx_en); // [RULE7] [RULE8]
  wire [7:0] ists_word = {global_pend, 1'b0, tx_pend, rx_pend};
  wire [7:0] evt_word  = {5'h00, evt_sts};
  wire [7:0] een_word  = {5'h00, evt_en};

  // receiver sources also see the async pin on port 0
  wire [NUM_RX-1:0] rx_set = rx_i.event_set | {{(NUM_RX-1){1'b0}}, pin_rise};
  wire [NUM_RX-1:0] rd_a   = rd_a_seen | rx_i.read_port_a;
  wire [NUM_RX-1:0] rd_b   = rd_b_seen | rx_i.read_port_b;
  wire [NUM_RX-1:0] rd_s   = rd_s_seen | rx_i.read_stream;
  wire [NUM_RX-1:0] rx_done = rd_a & rd_b & rd_s;

  wire [NUM_TX-1:0] next_tx_pend = tx_event_i | (tx_pend & ~tx_sts_read_i); // [RULE9]
  wire [NUM_RX-1:0] next_rx_pend = rx_set | (rx_pend & ~rx_done); // [RULE10]

  // local event sources
  wire [NUM_EVT-1:0] evt_set = {~irq_q & irq_o, global_pend & ~global_pend_q, lev0 | lev1};
  wire [NUM_EVT-1:0] evt_clr = wr_eclr ? wdata_i[NUM_EVT-1:0] : {NUM_EVT{1'b0}};

  // read mux
  wire [7:0] next_rdata = rd_fwd  ? fwd_word  :
                          rd_ctl  ? irq_ctl   :
                          rd_ists ? ists_word :
                          (rd_i && addr_i == ADDR_EVT_STS) ? evt_word :
                          (rd_i && addr_i == ADDR_EVT_EN)  ? een_word : 8'h00;

  // control register and read data
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_ctl <= IRQ_CTL_RESET; // [RULE11]
      rdata_o <= 8'h00;
      evt_en  <= '0;
    end else if (ce_i) begin
      if (wr_ctl) begin
        irq_ctl <= {wdata_i[7], 1'b0, wdata_i[5:0]}; // [RULE5] [RULE6]
      end
      if (wr_een) begin
        evt_en <= wdata_i[NUM_EVT-1:0];
      end
      rdata_o <= next_rdata;
    end
  end

  // pending sources; set beats clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_pend   <= '0;
      rx_pend   <= '0;
      rd_a_seen <= '0;
      rd_b_seen <= '0;
      rd_s_seen <= '0;
    end else if (ce_i) begin
      tx_pend   <= next_tx_pend;
      rx_pend   <= next_rx_pend;
      rd_a_seen <= rd_a & rx_pend & ~rx_done; // per port, a done port forgets only its own
      rd_b_seen <= rd_b & rx_pend & ~rx_done;
      rd_s_seen <= rd_s & rx_pend & ~rx_done;
    end
  end

  // edge history and sticky events
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      global_pend_q <= 1'b0;
      irq_q         <= 1'b0;
      pin_sync_d    <= 1'b0;
      evt_sts       <= '0;
    end else if (ce_i) begin
      global_pend_q <= global_pend;
      irq_q         <= irq_o;
      pin_sync_d    <= pin_sync;
      evt_sts       <= evt_set | (evt_sts & ~evt_clr);
    end
  end

  // interrupt outputs
  assign irq_o     = irq_ctl[GLOBAL_BIT] & global_pend; // [RULE5] [RULE12]
  assign evt_irq_o = |(evt_sts & evt_en);

  a_irq_equals_gate : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    irq_o == (irq_ctl[GLOBAL_BIT] && |(irq_ctl[5:0] & ists_word[5:0])))
    else $error("irq gate wrong"); // [RULE12]
  a_pend_no_gen : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && tx_event_i[0] && tx_en[0] |=> ists_word[GLOBAL_BIT]) else $error("pending missed"); // [RULE8]
  a_tx_clear_read : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && tx_sts_read_i[1] && !tx_event_i[1] |=> !tx_pend[1]) else $error("tx not cleared"); // [RULE9]
  a_tx_set_event : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && tx_event_i[0] |=> tx_pend[0]) else $error("tx event lost"); // [RULE9]
  a_rx_hold_unread : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && rx_pend[0] && !rx_done[0] |=> rx_pend[0]) else $error("rx cleared early"); // [RULE10]
  a_fwd_read_clear : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    fwd_clr && !fwd0_i.sync_lost |=> !lost0) else $error("fail flag survived read"); // [RULE2]
  a_ctl_write_back : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && wr_ctl |=> irq_ctl[5:0] == $past(wdata_i[5:0])) else $error("control not stored"); // [RULE6]
  a_sync_follows : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && fwd0_i.fwd_enabled && fwd0_i.sync_ok |=> ok0) else $error("sync bit low"); // [RULE3]
endmodule

//--- logic/hif_pkg.sv
// How it works
// RULE1 - sync loss sets fail flag after frame
// RULE2 - reading forward status clears fail flags
// RULE3 - sync bit high while forwarding synchronized
// RULE4 - sync bit zero while forwarding disabled
// RULE5 - bit 7 global enable gates interrupt
// RULE6 - per-source enables in control bits 5..0
// RULE7 - pending bit set by enabled source
// RULE8 - pending ignores global enable
// RULE9 - transmitter bits set, cleared on status read
// RULE10 - receiver bits cleared after status reads
// RULE11 - control register resets to zero
// RULE12 - irq output equals enable and pending
// RULE13 - host reads global then source status
package hif_pkg;
  localparam logic [7:0] ADDR_FORWARD_SYNC_STATUS      = 8'h22;
  localparam logic [7:0] ADDR_IRQ_CTL      = 8'h23;
  localparam logic [7:0] ADDR_IRQ_STS      = 8'h24;
  localparam logic [7:0] ADDR_EVT_STS      = 8'h30;
  localparam logic [7:0] ADDR_EVT_CLR      = 8'h31;
  localparam logic [7:0] ADDR_EVT_EN       = 8'h32;
  localparam logic [7:0] IRQ_CTL_RESET     = 8'h00;
  localparam logic [7:0] FORWARD_SYNC_STATUS_RESET     = 8'h00;
  localparam int         GLOBAL_BIT        = 7;
  localparam int         TX_LSB            = 4;
  localparam int         RX_LSB            = 0;
  localparam int         FAIL_LSB          = 2;
  localparam int         SYNC_LSB          = 0;
  localparam int         NUM_RX            = 4;
  localparam int         NUM_TX            = 2;
  localparam int         NUM_EVT           = 3;
  localparam int         EVT_SYNC_LOST     = 0;
  localparam int         EVT_PENDING_RISE  = 1;
  localparam int         EVT_IRQ_RISE      = 2;

  // per-output forwarding engine report
  typedef struct packed {
    logic       fwd_enabled;
    logic       sync_ok;
    logic       frame_done;
    logic       sync_lost;
  } hif_fwd_t;

  // receiver port event and status-read strobes
  typedef struct packed {
    logic [NUM_RX-1:0] event_set;
    logic [NUM_RX-1:0] read_port_a;
    logic [NUM_RX-1:0] read_port_b;
    logic [NUM_RX-1:0] read_stream;
  } hif_rx_t;
endpackage

//--- logic/hif_sync3.sv
module hif_sync3
  import hif_pkg::*;
(
  input  wire logic core_clk_i,  // clock
  input  wire logic rstn_i,      // async reset
  input  wire logic ce_i,        // clock enable
  input  wire logic async_i,     // foreign input
  output logic      sync_o       // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  // three stages, accept when second and third agree
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1     <= 1'b0;
      s2     <= 1'b0;
      s3     <= 1'b0;
      sync_o <= 1'b0;
    end else if (ce_i) begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_o <= s3;
      end
    end
  end
endmodule

//--- logic/hif_fwd_port.sv
module hif_fwd_port
  import hif_pkg::*;
(
  input  wire logic      core_clk_i,  // clock
  input  wire logic      rstn_i,      // async reset
  input  wire logic      ce_i,        // clock enable
  input  wire hif_fwd_t  fwd_i,       // engine report
  input  wire logic      clr_i,       // status read clear
  output logic           sync_ok_o,   // synchronized now
  output logic           lost_o,      // sticky sync lost
  output logic           lost_evt_o   // one-cycle new loss
);
  logic armed;
  wire  loss_seen = fwd_i.fwd_enabled && armed && fwd_i.sync_lost;
  wire  next_lost = loss_seen | (lost_o & ~clr_i);

  // sync bit forced low when forwarding off
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_ok_o <= 1'b0;
    end else if (ce_i) begin
      sync_ok_o <= fwd_i.fwd_enabled & fwd_i.sync_ok; // [RULE3] [RULE4]
    end
  end

  // arm once a frame was sent; set beats read clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed  <= 1'b0;
      lost_o <= 1'b0;
    end else if (ce_i) begin
      if (!fwd_i.fwd_enabled) begin
        armed <= 1'b0;
      end else if (fwd_i.frame_done) begin
        armed <= 1'b1;
      end
      lost_o <= next_lost; // [RULE1] [RULE2]
    end
  end

  assign lost_evt_o = loss_seen & ce_i & ~lost_o;

  a_lost_needs_arm : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && !lost_o && !armed |=> !lost_o) else $error("loss set before a frame"); // [RULE1]
  a_sync_off_zero : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ce_i && !fwd_i.fwd_enabled |=> !sync_ok_o) else $error("sync bit while disabled"); // [RULE4]
endmodule

//--- tb/hif_engine_model.sv
module hif_engine_model
  import hif_pkg::*;
(
  input  wire logic core_clk_i,  // clock
  input  wire logic rstn_i,      // async reset
  input  wire logic en_i,        // forwarding mode on
  input  wire logic lock_i,      // inputs aligned
  input  wire logic frame_i,     // one aligned frame sent
  input  wire logic lose_i,      // alignment lost
  output hif_fwd_t  fwd_o        // report to the hub
);
  // registered report; lock may stay stale while disabled
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fwd_o <= '0;
    end else begin
      fwd_o <= {en_i, lock_i, frame_i & en_i, lose_i & en_i};
    end
  end
endmodule

//--- tb/testbench.sv
module testbench
  import hif_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk_i, rstn_i, wr_i, rd_i, irq_o, evt_irq_o, ce_i, pin;
  logic [7:0]  addr_i, wdata_i, rdata_o, rv, v, e;
  logic [1:0]  tx_event_i, tx_sts_read_i, en, lock, frame, lose;
  logic [31:0] seed = 32'h12AC;
  logic [31:0] r;
  hif_fwd_t    fwd0_i, fwd1_i;
  hif_rx_t     rx_i;
  int          bad_count, samples_checked, k;

  hif_irq_hub i_hif_irq_hub (.core_clk_i, .rstn_i, .ce_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .fwd0_i, .fwd1_i, .tx_event_i, .tx_sts_read_i, .rx_i,
    .rx_pin_evt_i(pin), .irq_o, .evt_irq_o);
  hif_engine_model i_hif_engine_model_0 (.core_clk_i, .rstn_i, .en_i(en[0]),
    .lock_i(lock[0]), .frame_i(frame[0]), .lose_i(lose[0]), .fwd_o(fwd0_i));
  hif_engine_model i_hif_engine_model_1 (.core_clk_i, .rstn_i, .en_i(en[1]),
    .lock_i(lock[1]), .frame_i(frame[1]), .lose_i(lose[1]), .fwd_o(fwd1_i));

  // 40 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected status: pending ignores the global enable
  function automatic logic [7:0] exp_sts(input logic [7:0] c, input logic [5:0] s);
    return {|(c[5:0] & s), 1'b0, s};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask

  // one-cycle source pulses
  task automatic txp(input logic [3:0] m);
    @(posedge core_clk_i);
    {tx_event_i, tx_sts_read_i} <= m;
    @(posedge core_clk_i);
    {tx_event_i, tx_sts_read_i} <= '0;
  endtask

  task automatic rxp(input logic [15:0] m);
    @(posedge core_clk_i);
    rx_i <= hif_rx_t'(m);
    @(posedge core_clk_i);
    rx_i <= '0;
  endtask

  task automatic fp(input logic [3:0] m);
    @(posedge core_clk_i);
    {frame, lose} <= m;
    @(posedge core_clk_i);
    {frame, lose} <= '0;
  endtask

  task automatic fset(input logic en_v, input logic lock_v);
    @(posedge core_clk_i);
    en <= {2{en_v}} & (2'b01 << k);
    lock <= {2{lock_v}} & (2'b01 << k);
    repeat (3) @(posedge core_clk_i);
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    {rstn_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    {tx_event_i, tx_sts_read_i, en, lock, frame, lose} = '0;
    rx_i = '0;
    ce_i = 1'b1;
    pin = 1'b0;
    repeat (10) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(ADDR_IRQ_CTL);
    chk(rv, 8'h00);
    rd(ADDR_IRQ_STS);
    chk(rv, 8'h00);
    rd(ADDR_FORWARD_SYNC_STATUS);
    chk(rv, 8'h00);
    wr(ADDR_IRQ_STS, 8'hFF);
    rd(ADDR_IRQ_STS);
    chk(rv, 8'h00);
    rd(8'h40);
    chk(rv, 8'h00);
    // transmitter sources, global enable off then on
    for (k = 0; k < 2; k++) begin
      wr(ADDR_IRQ_CTL, 8'h30);
      txp(4'h4 << k);
      rd(ADDR_IRQ_STS);
      chk(rv, 8'h80 | (8'h10 << k));
      chk(irq_o, 8'h00);
      wr(ADDR_IRQ_CTL, 8'hB0);
      #1 chk(irq_o, 8'h01);
      txp(4'h1 << k);
      rd(ADDR_IRQ_STS);
      chk(rv, 8'h00);
      chk(irq_o, 8'h00);
    end
    // local events: pending rise and interrupt rise both seen
    rd(ADDR_EVT_STS);
    chk(rv, 8'h06);
    wr(ADDR_EVT_CLR, 8'h06);
    rd(ADDR_EVT_STS);
    chk(rv, 8'h00);
    // receiver sources under random enables
    for (int i = 0; i < 8; i++) begin
      r = xs();
      v = r[7:0];
      k = int'(r[9:8]);
      wr(ADDR_IRQ_CTL, v);
      rd(ADDR_IRQ_CTL);
      chk(rv, v & 8'hBF);
      rxp(16'h1000 << k);
      e = exp_sts(v, 6'h01 << k);
      rd(ADDR_IRQ_STS);
      chk(rv, e);
      chk(irq_o, {7'h00, e[7] & v[7]});
      rxp(16'h0100 << k);
      rxp(16'h0001 << k);
      rd(ADDR_IRQ_STS);
      chk(rv, e);
      rxp(16'h0010 << k);
      rd(ADDR_IRQ_STS);
      chk(rv, exp_sts(v, 6'h00));
    end
    // filtered pin rise is a receiver port 0 event
    wr(ADDR_IRQ_CTL, 8'h01);
    @(posedge core_clk_i);
    pin <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    rd(ADDR_IRQ_STS);
    chk(rv, exp_sts(8'h01, 6'h01));
    rxp(16'h0111);
    rd(ADDR_IRQ_STS);
    chk(rv, 8'h00);
    pin <= 1'b0;
    // forwarding status per output port
    wr(ADDR_EVT_EN, 8'h01);
    rd(ADDR_EVT_EN);
    chk(rv, 8'h01);
    for (k = 0; k < 2; k++) begin
      fset(1'b1, 1'b1);
      rd(ADDR_FORWARD_SYNC_STATUS);
      chk(rv, 8'h01 << k);
      fset(1'b0, 1'b1);
      rd(ADDR_FORWARD_SYNC_STATUS);
      chk(rv, 8'h00);
      fset(1'b1, 1'b1);
      fp(4'h1 << k);
      fset(1'b1, 1'b1);
      rd(ADDR_FORWARD_SYNC_STATUS);
      chk(rv, 8'h01 << k);
      fp(4'h4 << k);
      fp(4'h1 << k);
      fset(1'b1, 1'b0);
      // read under a low clock enable is not taken and clears nothing
      ce_i <= 1'b0;
      rd(ADDR_FORWARD_SYNC_STATUS);
      chk(rv, 8'h00);
      ce_i <= 1'b1;
      rd(ADDR_FORWARD_SYNC_STATUS);
      chk(rv, 8'h04 << k);
      rd(ADDR_FORWARD_SYNC_STATUS);
      chk(rv, 8'h00);
      chk(evt_irq_o, 8'h01);
      wr(ADDR_EVT_CLR, 8'h01);
      #1 chk(evt_irq_o, 8'h00);
      fset(1'b0, 1'b0);
    end
    wrap_up();
  end
endmodule
